// [rtl/ldc_defines.svh]
// constants of the lcd drive control block: register addresses, field
// positions, reset values and frame divider counts.
// assumes a 16-bit byte address bus and the system clock at 100 MHz.
`ifndef LDC_DEFINES_SVH
`define LDC_DEFINES_SVH

// ****************************************************************
// register addresses
// ****************************************************************
`define LDC_ADDR_PORT_CTL  16'hFFC0
`define LDC_ADDR_LCR       16'hFFC1
`define LDC_ADDR_LCD_DRIVE_CONTROL_TWO      16'hFFC2
`define LDC_ADDR_CKSTP2    16'hFFFB

// ****************************************************************
// reset values
// ****************************************************************
`define LDC_PORT_CTL_RST   8'h00
`define LDC_LCR_RST        8'h80
`define LDC_LCD_DRIVE_CONTROL_TWO_RST       8'h60
`define LDC_CKSTP2_RST     8'hFF

// ****************************************************************
// field positions
// ****************************************************************
`define LDC_LCR_RSV_BIT    7
`define LDC_LCR_PSW_BIT    6
`define LDC_LCR_ACT_BIT    5
`define LDC_LCR_SHOW_MEMORY_DATA_BIT   4
`define LDC_LCR_CKS_MSB    3
`define LDC_LCD_DRIVE_CONTROL_TWO_AB_BIT    7
`define LDC_LCD_DRIVE_CONTROL_TWO_RSV_HI    6
`define LDC_LCD_DRIVE_CONTROL_TWO_RSV_LO    5
`define LDC_LCD_DRIVE_CONTROL_TWO_SUPPLY_SOURCE_SELECT_BIT  4
`define LDC_LCD_DRIVE_CONTROL_TWO_CDS_MSB   3
`define LDC_PCTL_DTS_MSB   7
`define LDC_PCTL_DTS_LSB   6
`define LDC_CKSTP_LCD_BIT  0

// ****************************************************************
// encodings and counts
// ****************************************************************
`define LDC_DUTY_THIRD     2'h2
`define LDC_CDS_HIGH       4'h0
`define LDC_CDS_LOW        4'h7
`define LDC_FRM_WATCH      9'h100
`define LDC_FRM_WATCH_3    9'h0C0
`define LDC_FRM_SYS        10'h200
`define LDC_FRM_SYS_3      10'h180

`endif

// [rtl/ldc_pkg.sv]
// types of the lcd drive control block.
// assumes ldc_defines.svh is on the include path.
package ldc_pkg;
  `include "ldc_defines.svh"

  // plain register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } ldc_bus_req_t;

  // drive controls towards the panel drivers and supply
  typedef struct packed {
    logic drive_supply_on;
    logic booster_run;
    logic supply_5v_sel;
    logic waveform_b;
    logic ctrl_running;
    logic show_data;
    logic [1:0] duty_sel;
    logic frame_tick;
    logic ladder_connect;
  } ldc_drive_t;

  // complete state of the block
  typedef struct packed {
    logic [7:0] port_ctl;
    logic [7:0] lcd_drive_control;
    logic [7:0] lcd_drive_control_two;
    logic [7:0] ckstp;
    logic [7:0] rdata;
    logic [7:0] pre;
    logic [1:0] wdiv;
    logic       op_tick;
    logic [9:0] frame_cnt;
    logic [4:0] lad_cnt;
    ldc_drive_t drv;
  } ldc_state_t;
endpackage : ldc_pkg

// [rtl/ldc_top.sv]
// lcd drive control: control registers, supply gating, frame clock selection,
// frame timing and charge/discharge pulse for the resistor ladder.
// assumes watch_tick is a one-cycle pulse at the watch clock rate, and all
// inputs are synchronous to clk.
// Behaviour
// - bit 7 of drive control reads one; writes to it do nothing
// - drive control resets to 0x80: supply off, halted, blank, watch clock
// - supply on only with switch set, activate set and no standby
// - activate clear halts everything but the booster, forces supply off, keeps registers
// - display-data bit zero shows blank, one shows memory contents
// - clock field picks watch clock 1,2,4 or system clock 2 to 256
// - with the system clock stopped, system-divider selections show nothing
// - at 32.768 kHz watch clock, frames are 128, 64, 32 Hz
// - one-third duty makes frame frequency four thirds of the others
// - second drive control resets to 0x60
// - waveform bit zero picks waveform A, one picks waveform B
// - bits 6 and 5 of second drive control read one, unwritable
// - supply select zero: main rail, booster off; one: 5 V, booster on
// - ladder duty: 0 high, 1-6 eighths, 7 low, 10xx 1/16, 11xx 1/32
// - zero ladder duty keeps the ladder disconnected permanently
// - ladder duty is connected time over pulse period
// - module standby bit zero holds module in standby, resets to one
// - duty select field picks static, half, third, quarter; sets frame timing
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ldc_top
  import ldc_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [15:0]  addr,
  input  wire logic [7:0]   wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  input  wire logic         watch_tick,
  input  wire logic         sys_clk_run,
  input  wire logic         chip_standby,
  output logic [7:0]        rdata,
  output ldc_pkg::ldc_drive_t drive
);
  import ldc_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  ldc_state_t st_r;
  ldc_state_t st_nxt;

  // decoded control fields
  logic       drive_supply_switch;
  logic       act;
  logic       show_memory_data;
  logic [3:0] cks;
  logic [3:0] cds;
  logic       released;
  logic       running;
  logic       third;
  logic [7:0] pre_mask;
  logic       sys_tick;
  logic       watch_sel_tick;
  logic [9:0] frame_lim;

  assign drive_supply_switch      = st_r.lcd_drive_control[`LDC_LCR_PSW_BIT];
  assign act      = st_r.lcd_drive_control[`LDC_LCR_ACT_BIT];
  assign show_memory_data     = st_r.lcd_drive_control[`LDC_LCR_SHOW_MEMORY_DATA_BIT];
  assign cks      = st_r.lcd_drive_control[`LDC_LCR_CKS_MSB:0];
  assign cds      = st_r.lcd_drive_control_two[`LDC_LCD_DRIVE_CONTROL_TWO_CDS_MSB:0];
  assign released = st_r.ckstp[`LDC_CKSTP_LCD_BIT];
  // halted by activate clear, module standby or chip standby
  assign running  = act && released && !chip_standby;
  assign third    = (st_r.port_ctl[`LDC_PCTL_DTS_MSB:`LDC_PCTL_DTS_LSB] == `LDC_DUTY_THIRD);

  // ****************************************************************
  // operating clock selection
  // ****************************************************************
  // system divider: tick every 2^(n+1) clocks, the low bits of pre all ones
  always_comb begin
    pre_mask = 8'hFF >> (3'h7 - cks[2:0]);
    sys_tick = sys_clk_run && ((st_r.pre & pre_mask) == pre_mask);
  end

  // watch divider: 1, 2 or 4 watch ticks per operating tick, bit 2 ignored
  always_comb begin
    if (cks[1]) begin
      watch_sel_tick = watch_tick && (st_r.wdiv == 2'h3);
    end else if (cks[0]) begin
      watch_sel_tick = watch_tick && st_r.wdiv[0];
    end else begin
      watch_sel_tick = watch_tick;
    end
  end

  // frame length in operating ticks; third duty shortens it by a quarter
  always_comb begin
    if (cks[3]) begin
      frame_lim = third ? `LDC_FRM_SYS_3 : `LDC_FRM_SYS;
    end else begin
      frame_lim = third ? {1'b0, `LDC_FRM_WATCH_3} : {1'b0, `LDC_FRM_WATCH};
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  // register writes are kept while halted, so software can set up first
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    if (wr) begin
      unique case (addr)
        `LDC_ADDR_PORT_CTL: st_nxt.port_ctl = wdata;
        `LDC_ADDR_LCR:      st_nxt.lcd_drive_control = {1'b1, wdata[6:0]};
        `LDC_ADDR_LCD_DRIVE_CONTROL_TWO:     st_nxt.lcd_drive_control_two = {wdata[7], 2'h3, wdata[4:0]};
        `LDC_ADDR_CKSTP2:   st_nxt.ckstp = wdata;
        default:            st_nxt.ckstp = st_r.ckstp;
      endcase
    end
    // read data stands only in the cycle after the strobe
    if (rd) begin
      unique case (addr)
        `LDC_ADDR_PORT_CTL: st_nxt.rdata = st_r.port_ctl;
        `LDC_ADDR_LCR:      st_nxt.rdata = st_r.lcd_drive_control | 8'h80;
        `LDC_ADDR_LCD_DRIVE_CONTROL_TWO:     st_nxt.rdata = st_r.lcd_drive_control_two | 8'h60;
        `LDC_ADDR_CKSTP2:   st_nxt.rdata = st_r.ckstp;
        default:            st_nxt.rdata = 8'h00;
      endcase
    end

    // dividers only advance while running; counters freeze in halt
    if (running) begin
      if (sys_clk_run) begin
        st_nxt.pre = st_r.pre + 8'h01;
      end
      if (watch_tick) begin
        st_nxt.wdiv = st_r.wdiv + 2'h1;
      end
      st_nxt.op_tick = cks[3] ? sys_tick : watch_sel_tick;
    end else begin
      st_nxt.op_tick = 1'b0;
    end

    // frame counter on operating ticks
    st_nxt.drv.frame_tick = 1'b0;
    if (running && st_r.op_tick) begin
      if (st_r.frame_cnt >= frame_lim - 10'h001) begin
        st_nxt.frame_cnt      = 10'h000;
        st_nxt.drv.frame_tick = 1'b1;
      end else begin
        st_nxt.frame_cnt = st_r.frame_cnt + 10'h001;
      end
      st_nxt.lad_cnt = st_r.lad_cnt + 5'h01;
    end

    // ladder pulse: period of 32 operating ticks, duty = connected/period
    if (!running) begin
      st_nxt.drv.ladder_connect = 1'b0;
    end else if (cds == `LDC_CDS_HIGH) begin
      st_nxt.drv.ladder_connect = 1'b1;
    end else if (cds == `LDC_CDS_LOW) begin
      st_nxt.drv.ladder_connect = 1'b0;
    end else if (!cds[3]) begin
      st_nxt.drv.ladder_connect = ({1'b0, st_nxt.lad_cnt[4:2]} < cds);
    end else if (!cds[2]) begin
      st_nxt.drv.ladder_connect = (st_nxt.lad_cnt[4:1] == 4'h0);
    end else begin
      st_nxt.drv.ladder_connect = (st_nxt.lad_cnt == 5'h00);
    end

    // static drive controls
    st_nxt.drv.drive_supply_on = drive_supply_switch && running;
    st_nxt.drv.ctrl_running    = running;
    st_nxt.drv.show_data       = show_memory_data && running;
    st_nxt.drv.waveform_b      = st_r.lcd_drive_control_two[`LDC_LCD_DRIVE_CONTROL_TWO_AB_BIT];
    st_nxt.drv.supply_5v_sel   = st_r.lcd_drive_control_two[`LDC_LCD_DRIVE_CONTROL_TWO_SUPPLY_SOURCE_SELECT_BIT];
    st_nxt.drv.booster_run     = st_r.lcd_drive_control_two[`LDC_LCD_DRIVE_CONTROL_TWO_SUPPLY_SOURCE_SELECT_BIT];
    st_nxt.drv.duty_sel        = st_r.port_ctl[`LDC_PCTL_DTS_MSB:`LDC_PCTL_DTS_LSB];
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // all registers to documented reset values; everything else cleared
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r          <= '0;
      st_r.port_ctl <= `LDC_PORT_CTL_RST;
      st_r.lcd_drive_control      <= `LDC_LCR_RST;
      st_r.lcd_drive_control_two     <= `LDC_LCD_DRIVE_CONTROL_TWO_RST;
      st_r.ckstp    <= `LDC_CKSTP2_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign drive = st_r.drv;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  AST_LCR_RSV: assert property (rd && addr == `LDC_ADDR_LCR |=> rdata[7])
    else $error("reserved bit 7 of drive control read as zero");
  AST_LCD_DRIVE_CONTROL_TWO_RSV: assert property (rd && addr == `LDC_ADDR_LCD_DRIVE_CONTROL_TWO |=> rdata[6:5] == 2'h3)
    else $error("reserved bits of second drive control read as zero");
  AST_SUPPLY: assert property (drive.drive_supply_on |-> $past(drive_supply_switch) && $past(act)
                               && !$past(chip_standby) && $past(released))
    else $error("drive supply on without switch, activate and no standby");
  AST_HALT: assert property (!act |=> !drive.drive_supply_on && !drive.ctrl_running
                             ##1 !drive.frame_tick)
    else $error("controller still active after activate cleared");
  AST_BLANK: assert property (!show_memory_data |=> !drive.show_data)
    else $error("memory data shown while display bit clear");
  AST_SYS_STOP: assert property ((cks[3] && !sys_clk_run) [*2] |=> !st_r.op_tick)
    else $error("system divider ticked with system clock stopped");
  AST_BOOST: assert property (drive.booster_run == drive.supply_5v_sel)
    else $error("booster and supply select disagree");
  // a second write may land right behind, so compare with the value that was registered
  AST_BOOST_FOLLOW: assert property ($changed(st_r.lcd_drive_control_two[`LDC_LCD_DRIVE_CONTROL_TWO_SUPPLY_SOURCE_SELECT_BIT])
                                     |=> drive.booster_run == $past(st_r.lcd_drive_control_two[`LDC_LCD_DRIVE_CONTROL_TWO_SUPPLY_SOURCE_SELECT_BIT]))
    else $error("booster not following supply select");
  AST_LAD_LOW: assert property (cds == `LDC_CDS_LOW |=> !drive.ladder_connect)
    else $error("ladder connected at zero duty");
  AST_LAD_HIGH: assert property (cds == `LDC_CDS_HIGH && running |=> drive.ladder_connect)
    else $error("ladder not connected at full duty");
  AST_STANDBY: assert property (!released |=> !drive.frame_tick && !drive.ladder_connect)
    else $error("module active in module standby");
  AST_WAVE: assert property (wr && addr == `LDC_ADDR_LCD_DRIVE_CONTROL_TWO |=> ##1 drive.waveform_b == $past(wdata[7], 2))
    else $error("waveform select not following register");
  AST_FRAME: assert property (drive.frame_tick |-> $past(st_r.op_tick))
    else $error("frame tick without operating tick");

  // ****************************************************************
  // further checks on register port, stored registers, drive bundle and frame counter
  // ****************************************************************
  // read data must drop back to zero so a stale byte is never taken twice
  AST_RDATA_IDLE: assert property (!rd |=> rdata == 8'h00)
    else $error("read data present without a read strobe");
  // chip standby alone must remove the drive supply
  AST_STBY_OFF: assert property (chip_standby |=> !drive.drive_supply_on)
    else $error("drive supply on during chip standby");
  // memory data shown whenever display bit is set and the block runs
  AST_SHOW: assert property (show_memory_data && running |=> drive.show_data)
    else $error("memory data not shown while enabled");
  // a halted block leaves the ladder disconnected
  AST_LAD_HALT: assert property (!running |=> !drive.ladder_connect)
    else $error("ladder connected while halted");
  // duty select output mirrors the port control field one cycle later
  AST_DUTY_SEL: assert property (drive.duty_sel
                                 == $past(st_r.port_ctl[`LDC_PCTL_DTS_MSB:`LDC_PCTL_DTS_LSB]))
    else $error("duty select output not following port control");
  // reserved bits are never stored as zero, whatever software writes
  AST_LCR_HOLD: assert property (st_r.lcd_drive_control[`LDC_LCR_RSV_BIT])
    else $error("reserved bit of drive control stored as zero");
  AST_LCD_DRIVE_CONTROL_TWO_HOLD: assert property (st_r.lcd_drive_control_two[`LDC_LCD_DRIVE_CONTROL_TWO_RSV_HI:`LDC_LCD_DRIVE_CONTROL_TWO_RSV_LO] == 2'h3)
    else $error("reserved bits of second drive control stored as zero");
  // the frame counter never passes the longest frame
  AST_FRAME_CNT: assert property (st_r.frame_cnt < 10'h200)
    else $error("frame counter beyond longest frame");

endmodule : ldc_top

`default_nettype wire

// [dv/ldc_panel_model.sv]
// panel-side model of the lcd drive control block: watches the drive bundle
// and measures the spacing of frame ticks in clock cycles.
// assumes drive is registered on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none

module ldc_panel_model
  import ldc_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           resetn,
  input  wire ldc_pkg::ldc_drive_t drive,
  output logic [15:0]         last_period,
  output logic [15:0]         frames
);
  logic [15:0] gap;

  // a panel only sees frames; the gap is kept so the bench can judge rates
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap         <= 16'h0001;
      last_period <= 16'h0000;
      frames      <= 16'h0000;
    end else if (drive.frame_tick) begin
      last_period <= gap;
      gap         <= 16'h0001;
      frames      <= frames + 16'h0001;
    end else begin
      gap <= gap + 16'h0001;
    end
  end
endmodule : ldc_panel_model
`default_nettype wire

// [dv/ldc_top_tb.sv]
// self-checking bench of the lcd drive control block.
// assumes the rtl package and defines are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "ldc_defines.svh"

module ldc_top_tb;
  import ldc_pkg::*;
  logic        clk = 0, resetn = 0, wr = 0, rd = 0, watch_tick = 0;
  logic        sys_clk_run = 1, chip_standby = 0;
  logic [15:0] addr = 16'h0000, last_period, frames;
  logic [7:0]  wdata = 8'h00, rdata;
  logic [1:0]  wt_cnt = 2'h0;
  ldc_drive_t  drive;
  int          err_count = 0, num_checks = 0, cyc = 0;

  ldc_top u_ldc_top (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .watch_tick(watch_tick), .sys_clk_run(sys_clk_run), .chip_standby(chip_standby),
    .rdata(rdata), .drive(drive));
  ldc_panel_model u_ldc_panel_model (.clk(clk), .resetn(resetn), .drive(drive),
    .last_period(last_period), .frames(frames));

  always #5 clk = ~clk;

  // watch clock stand-in: one pulse every fourth system clock
  always @(posedge clk) begin
    wt_cnt     <= wt_cnt + 2'h1;
    watch_tick <= (wt_cnt == 2'h3);
  end

  // hang guard, well above the summed frame waits
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe edge
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk("rdata", {8'h00, exp}, {8'h00, rdata});
  endtask : rd_chk

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic t_regs();
    rd_chk(`LDC_ADDR_LCR, 8'h80);
    rd_chk(`LDC_ADDR_LCD_DRIVE_CONTROL_TWO, 8'h60);
    rd_chk(`LDC_ADDR_CKSTP2, 8'hFF);
    rd_chk(`LDC_ADDR_PORT_CTL, 8'h00);
    wr_reg(`LDC_ADDR_LCR, 8'h00);
    rd_chk(`LDC_ADDR_LCR, 8'h80);
    wr_reg(`LDC_ADDR_LCD_DRIVE_CONTROL_TWO, 8'h9F);
    rd_chk(`LDC_ADDR_LCD_DRIVE_CONTROL_TWO, 8'hFF);
    wr_reg(`LDC_ADDR_LCD_DRIVE_CONTROL_TWO, 8'h00);
    rd_chk(`LDC_ADDR_LCD_DRIVE_CONTROL_TWO, 8'h60);
    rd_chk(16'h1234, 8'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_gate();
    wr_reg(`LDC_ADDR_LCR, 8'hF0);
    settle();
    chk("supply", 16'h1, {15'h0, drive.drive_supply_on});
    chk("show", 16'h1, {15'h0, drive.show_data});
    chip_standby <= 1'b1;
    settle();
    chk("supply", 16'h0, {15'h0, drive.drive_supply_on});
    chip_standby <= 1'b0;
    wr_reg(`LDC_ADDR_CKSTP2, 8'hFE);
    settle();
    chk("running", 16'h0, {15'h0, drive.ctrl_running});
    wr_reg(`LDC_ADDR_CKSTP2, 8'hFF);
    wr_reg(`LDC_ADDR_LCR, 8'hD0);
    settle();
    chk("supply", 16'h0, {15'h0, drive.drive_supply_on});
    rd_chk(`LDC_ADDR_LCR, 8'hD0);
    wr_reg(`LDC_ADDR_LCR, 8'hE0);
    wr_reg(`LDC_ADDR_LCD_DRIVE_CONTROL_TWO, 8'h90);
    settle();
    chk("show", 16'h0, {15'h0, drive.show_data});
    chk("wave_b", 16'h1, {15'h0, drive.waveform_b});
    chk("boost", 16'h3, {14'h0, drive.booster_run, drive.supply_5v_sel});
    $display("test gate done");
  endtask : t_gate

  // frame spacing in clocks: watch tick every 4 clocks, 256, 384 or 512 ticks a frame
  task automatic t_frame();
    logic [7:0]  cfg [6] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h09, 8'h08};
    logic [15:0] exp [6] = '{16'd1024, 16'd2048, 16'd4096, 16'd1024, 16'd2048, 16'd768};
    logic [15:0] f0;
    for (int i = 0; i < 6; i++) begin
      if (i == 5) wr_reg(`LDC_ADDR_PORT_CTL, 8'h80);
      wr_reg(`LDC_ADDR_LCR, 8'hE0 | cfg[i]);
      repeat (2 * exp[i] + 20) @(posedge clk);
      chk("frame_period", exp[i], last_period);
      if (i == 5) chk("duty_sel", 16'h2, {14'h0, drive.duty_sel});
    end
    sys_clk_run <= 1'b0;
    settle();
    f0 = frames;
    repeat (3000) @(posedge clk);
    chk("frames_stopped", f0, frames);
    sys_clk_run <= 1'b1;
    $display("test frame done");
  endtask : t_frame

  // system clock over 2: ladder period 64 clocks, 640 clocks sampled
  task automatic t_ladder();
    logic [7:0]  cds [5] = '{8'h07, 8'h00, 8'h04, 8'h08, 8'h0C};
    logic [15:0] exp [5] = '{16'd0, 16'd640, 16'd320, 16'd40, 16'd20};
    logic [15:0] n;
    wr_reg(`LDC_ADDR_LCR, 8'hE8);
    for (int i = 0; i < 5; i++) begin
      wr_reg(`LDC_ADDR_LCD_DRIVE_CONTROL_TWO, cds[i]);
      settle();
      n = 16'h0000;
      repeat (640) begin
        @(posedge clk);
        #1 n = n + {15'h0, drive.ladder_connect};
      end
      chk("ladder_high", exp[i], n);
    end
    $display("test ladder done");
  endtask : t_ladder

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_gate();
    t_frame();
    t_ladder();
    complete_run();
  end
endmodule : ldc_top_tb
`default_nettype wire
